//--- verif/sbt_rx_model.sv
// link receiver model for the segmented buffer transmit control block
// assumes one byte per valid pulse, words sent low byte first
`timescale 1ns/1ns
module sbt_rx_model
  import sbt_pkg::*;
(
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         clear_i,
  input  wire sbt_link_type link_i,
  output logic [11:0]       byte_cnt_o,
  output logic [11:0]       last_at_o,
  output logic [31:0]       first_w_o,
  output logic [31:0]       last_w_o,
  output logic              frame_err_o
);
  logic [31:0] acc_nxt;

  assign acc_nxt = {link_i.octet, last_w_o[31:8]};

  // takes buffer bytes only, skips shared bus slots
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i || clear_i) begin
      byte_cnt_o  <= 12'h000;
      last_at_o   <= 12'h000;
      first_w_o   <= 32'h0000_0000;
      last_w_o    <= 32'h0000_0000;
      frame_err_o <= 1'b0;
    end else if (link_i.valid && !link_i.dbus_slot) begin
      last_w_o   <= acc_nxt;
      byte_cnt_o <= byte_cnt_o + 12'h001;
      if (byte_cnt_o == 12'h003) begin
        first_w_o <= acc_nxt;
      end
      if (link_i.last) begin
        last_at_o <= byte_cnt_o + 12'h001;
      end
      if (link_i.first != (byte_cnt_o == 12'h000)) begin
        frame_err_o <= 1'b1;
      end
    end
  end
endmodule

//--- verif/testbench.sv
// self-checking bench for the segmented buffer transmit control block
// assumes AXI4-Lite register access and the link receiver model
`timescale 1ns/1ns
module testbench
  import sbt_pkg::*;
;
  logic            core_clk = 1'b0;
  logic            rst_n    = 1'b0;
  logic            clr      = 1'b0;
  sbt_axi_req_type req;
  sbt_axi_rsp_type rsp;
  sbt_link_type    link;
  logic            share;
  logic            irq;
  logic            ferr;
  logic [11:0]     bcnt;
  logic [11:0]     lastat;
  logic [11:0]     held;
  logic [31:0]     fw;
  logic [31:0]     lw;
  logic [31:0]     d;
  logic [1:0]      r;
  logic            prev_v;
  logic [11:0]     b2b;
  int              fail_count = 0;
  int              tests_run  = 0;
  int              cycles     = 0;

  sbt_tx_ctrl #(.DEPTH(BUF_DEPTH)) i_dut (
    .core_clk_i   (core_clk),
    .rst_n_i      (rst_n),
    .axi_req_i    (req),
    .axi_rsp_o    (rsp),
    .link_o       (link),
    .dbus_share_o (share),
    .irq_o        (irq)
  );

  sbt_rx_model i_rx (
    .core_clk_i  (core_clk),
    .rst_n_i     (rst_n),
    .clear_i     (clr),
    .link_i      (link),
    .byte_cnt_o  (bcnt),
    .last_at_o   (lastat),
    .first_w_o   (fw),
    .last_w_o    (lw),
    .frame_err_o (ferr)
  );

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  task automatic results();
    if (fail_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      results();
    end
  end

  // back to back data bytes on the link
  always @(posedge core_clk) begin
    prev_v <= link.valid;
    if (clr) begin
      b2b <= 12'h000;
    end else if (link.valid && prev_v) begin
      b2b <= b2b + 12'h001;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= v;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      if (!aw_ok && rsp.awready === 1'b1) begin
        aw_ok = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w_ok && rsp.wready === 1'b1) begin
        w_ok = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
  endtask

  task automatic rd(input logic [11:0] a);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    do @(posedge core_clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge core_clk); while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
  endtask

  task automatic clear_rx();
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
  endtask

  // control word: segment, {trigger, engine, mode}, length in words
  function automatic logic [31:0] cv(input logic [7:0] s,
                                     input logic [2:0] tem,
                                     input logic [8:0] l);
    cv = {s, 24'h0} | {13'h0, tem, 16'h0} | {21'h0, l, 2'h0};
  endfunction

  initial begin
    req        = '0;
    req.wstrb  = 4'hF;
    req.bready = 1'b1;
    req.rready = 1'b1;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(OFF_CTRL);
    chk(d, 32'h0, "ctrl reset");
    rd(12'h100);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(OFF_CTRL, cv(8'hA5, 3'h3, 9'h1FF) | 32'h3);
    rd(OFF_CTRL);
    chk(d, cv(8'hA5, 3'h3, 9'h1FF), "ctrl readback");
    chk({31'h0, share}, 32'h1, "share on");
    wr(12'h81C, 32'hDEADBEEF);
    wr(12'h820, 32'h44332211);
    wr(12'h824, 32'h88776655);
    wr(12'h828, 32'hCAFEF00D);
    wr(OFF_IEN, 32'h3);
    for (int m = 0; m < 2; m++) begin
      clear_rx();
      wr(OFF_CTRL, cv(8'h82, {2'b11, m[0]}, 9'h002));
      rd(OFF_CTRL);
      chk(d & 32'h001C0000, 32'h00080000, "running");
      do rd(OFF_CTRL); while (d[RUN_BIT] !== 1'b0);
      chk(d, cv(8'h82, {2'b01, m[0]}, 9'h002) | 32'h00100000, "done");
      chk({20'h0, bcnt}, 32'h8, "byte count");
      chk({20'h0, lastat}, 32'h8, "last marker");
      chk(fw, 32'h44332211, "first word");
      chk(lw, 32'h88776655, "last word");
      chk({31'h0, ferr}, 32'h0, "first marker");
      chk({31'h0, share}, {31'h0, m[0]}, "share mode");
      chk({20'h0, b2b}, m[0] ? 32'h0 : 32'h6, "slot sharing");
      rd(OFF_STAT);
      chk(d, 32'h3, "status events");
      chk({31'h0, irq}, 32'h1, "irq raised");
      wr(OFF_CLR, 32'h3);
      rd(OFF_STAT);
      chk(d, 32'h0, "status cleared");
      chk({31'h0, irq}, 32'h0, "irq cleared");
    end
    clear_rx();
    wr(OFF_CTRL, cv(8'h02, 3'h4, 9'h002));
    repeat (20) @(posedge core_clk);
    rd(OFF_CTRL);
    chk(d & 32'h000E0000, 32'h0, "engine off trigger");
    chk({20'h0, bcnt}, 32'h0, "no bytes when off");
    wr(OFF_CTRL, cv(8'h00, 3'h6, 9'h000));
    repeat (40) @(posedge core_clk);
    wr(OFF_CTRL, 32'h0);
    rd(OFF_CTRL);
    chk(d & 32'h00180000, 32'h0, "abort flags");
    held = bcnt;
    chk({31'h0, held != 12'h000}, 32'h1, "abort after start");
    repeat (20) @(posedge core_clk);
    chk({20'h0, bcnt}, {20'h0, held}, "abort stops link");
    results();
  end
endmodule

//--- verilog/sbt_buf_mem.sv
// word memory of the segmented buffer, byte-write port and read port
// assumes read data are taken one cycle after the read enable
`timescale 1ns/1ns
module sbt_buf_mem #(
  parameter int DEPTH = 1024,
  parameter int WIDTH = 32,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 we_i,
  input  wire logic [AW-1:0]        waddr_i,
  input  wire logic [WIDTH-1:0]     wdata_i,
  input  wire logic [WIDTH/8-1:0]   wstrb_i,
  input  wire logic                 re_i,
  input  wire logic [AW-1:0]        raddr_i,
  output logic      [WIDTH-1:0]     rdata_o
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  if (WIDTH % 8 != 0 || DEPTH != (1 << AW)) begin : g_bad
    $error("sbt_buf_mem: width or depth not supported");
  end

  // byte lane writes
  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      for (int i = 0; i < WIDTH / 8; i++) begin
        if (wstrb_i[i]) begin
          mem_r[waddr_i][i*8 +: 8] <= wdata_i[i*8 +: 8];
        end
      end
    end
  end

  // registered read, held while idle
  always_ff @(posedge core_clk_i) begin
    if (re_i) begin
      rdata_o <= mem_r[raddr_i];
    end
  end

endmodule

//--- verilog/sbt_pkg.sv
// package for the segmented buffer transmit control block
// assumes one 50 MHz clock and an AXI4-Lite master with 32-bit data
package sbt_pkg;

  localparam int          CLK_MHZ      = 50;
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 32;

  // register byte addresses
  localparam logic [11:0] OFF_CTRL     = 12'h028;
  localparam logic [11:0] OFF_STAT     = 12'h030;
  localparam logic [11:0] OFF_CLR      = 12'h034;
  localparam logic [11:0] OFF_IEN      = 12'h038;
  localparam logic [11:0] OFF_BUF      = 12'h800;

  // control register fields
  localparam int          SEG_LSB      = 24;
  localparam int          DONE_BIT     = 20;
  localparam int          RUN_BIT      = 19;
  localparam int          TRIG_BIT     = 18;
  localparam int          ENG_BIT      = 17;
  localparam int          MODE_BIT     = 16;
  localparam int          LEN_LSB      = 2;
  localparam int          LEN_W        = 9;
  localparam int          SEG_BYTES    = 16;
  localparam int          WORD_BYTES   = 4;

  // buffer geometry
  localparam int          BUF_DEPTH    = 1024;
  localparam int          MAX_WORDS    = 512;

  // interrupt events
  localparam int          EV_DONE      = 0;
  localparam int          EV_START     = 1;
  localparam int          EV_W         = 2;

  // reset values
  localparam logic [7:0]  SEG_RST      = 8'h00;
  localparam logic [8:0]  LEN_RST      = 9'h000;
  localparam logic [1:0]  IEN_RST      = 2'h0;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_FETCH = 2'h1,
    ST_SEND  = 2'h3,
    ST_END   = 2'h2
  } sbt_state_type;

  typedef struct packed {
    logic        valid;
    logic        first;
    logic        last;
    logic        dbus_slot;
    logic [7:0]  octet;
  } sbt_link_type;

  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } sbt_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sbt_axi_rsp_type;

endpackage

//--- verilog/sbt_tx_ctrl.sv
// segmented buffer transmit control: AXI4-Lite registers, buffer, engine
// assumes a 50 MHz clock, AXI4-Lite master, receivers that take every byte
//
// Summary of operation
// [RQ1] start segment in control bits 31:24, counted in 16-byte segments
// [RQ2] complete flag at bit 20 set when a triggered transfer finishes
// [RQ3] running flag at bit 19 set on trigger, held until transfer completes
// [RQ4] writing one to trigger bit 18 starts sending selected buffer data
// [RQ5] bit 17 low keeps the transmit engine disabled, high enables it
// [RQ6] bit 16 picks link sharing: zero unshared, one shared with bus
// [RQ7] length in bits 10:2, 4 bytes to 2k in words; bits 1:0 read zero
// [RQ8] read from segment times sixteen, send exactly the length, then complete
`timescale 1ns/1ns
module sbt_tx_ctrl
  import sbt_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic            core_clk_i,
  input  wire logic            rst_n_i,
  input  wire sbt_axi_req_type axi_req_i,
  output sbt_axi_rsp_type      axi_rsp_o,
  output sbt_link_type         link_o,
  output logic                 dbus_share_o,
  output logic                 irq_o
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < MAX_WORDS || DEPTH != (1 << AW) || AW > ADDR_W - 2 ||
      DEPTH * WORD_BYTES < 256 * SEG_BYTES) begin : g_bad
    $error("sbt_tx_ctrl: buffer depth not supported");
  end

  typedef struct packed {
    logic [7:0]       seg;
    logic             done;
    logic             run;
    logic             eng;
    logic             mode;
    logic [LEN_W-1:0] len;
    sbt_state_type    st;
    logic [LEN_W:0]   left;
    logic [AW-1:0]    waddr;
    logic [1:0]       bidx;
    logic             first;
    logic             slot;
    logic [EV_W-1:0]  stat;
    logic [EV_W-1:0]  ien;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    sbt_link_type     link;
  } sbt_regs_type;

  sbt_regs_type    r;
  sbt_regs_type    n;
  logic            wr_go;
  logic            rd_go;
  logic            trig_w;
  logic            start_go;
  logic            rd_ctrl;
  logic            mem_we;
  logic [AW-1:0]   mem_waddr;
  logic            mem_re;
  logic [AW-1:0]   mem_raddr;
  logic [31:0]     mem_rdata;

  // word-aligned register hit
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a[11:2] == o[11:2]);
  endfunction

  // first buffer word of a segment
  function automatic logic [AW-1:0] seg_word(input logic [7:0] s);
    seg_word = AW'({s, 2'b00});
  endfunction

  // words to send; zero stands for the full 2k
  function automatic logic [LEN_W:0] len_words(input logic [LEN_W-1:0] l);
    len_words = (l == '0) ? (LEN_W + 1)'(MAX_WORDS) : {1'b0, l};
  endfunction

  function automatic logic [31:0] ctrl_word(input sbt_regs_type s);
    ctrl_word            = 32'h0000_0000;
    ctrl_word[31:24]     = s.seg;
    ctrl_word[DONE_BIT]  = s.done;
    ctrl_word[RUN_BIT]   = s.run;
    ctrl_word[ENG_BIT]   = s.eng;
    ctrl_word[MODE_BIT]  = s.mode;
    ctrl_word[LEN_LSB +: LEN_W] = s.len;
  endfunction

  assign wr_go = axi_req_i.awvalid && axi_req_i.wvalid && !r.bvalid;
  assign rd_go = axi_req_i.arvalid && !r.rvalid;
  assign rd_ctrl = rd_go && hit(axi_req_i.araddr, OFF_CTRL);

  always_comb begin
    axi_rsp_o         = '0;
    axi_rsp_o.awready = wr_go;
    axi_rsp_o.wready  = wr_go;
    axi_rsp_o.bvalid  = r.bvalid;
    axi_rsp_o.bresp   = r.bresp;
    axi_rsp_o.arready = !r.rvalid;
    axi_rsp_o.rvalid  = r.rvalid;
    axi_rsp_o.rdata   = r.rdata;
    axi_rsp_o.rresp   = r.rresp;
  end

  assign link_o       = r.link;
  assign dbus_share_o = r.mode;
  assign irq_o        = |(r.stat & r.ien);

  always_comb begin
    n              = r;
    n.link         = '0;
    n.link.dbus_slot = 1'b1;
    trig_w         = 1'b0;
    start_go       = 1'b0;
    mem_we         = 1'b0;
    mem_waddr      = axi_req_i.awaddr[AW+1:2];
    mem_re         = 1'b0;
    mem_raddr      = r.waddr;

    // write channel
    if (r.bvalid && axi_req_i.bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.bvalid = 1'b1;
      n.bresp  = RESP_OKAY;
      if (hit(axi_req_i.awaddr, OFF_CTRL)) begin
        if (axi_req_i.wstrb[3]) begin
          n.seg = axi_req_i.wdata[SEG_LSB +: 8];           // [RQ1]
        end
        if (axi_req_i.wstrb[2]) begin
          trig_w = axi_req_i.wdata[TRIG_BIT];               // [RQ4]
          n.eng  = axi_req_i.wdata[ENG_BIT];                // [RQ5]
          n.mode = axi_req_i.wdata[MODE_BIT];               // [RQ6]
        end
        if (axi_req_i.wstrb[1]) begin
          n.len[LEN_W-1:6] = axi_req_i.wdata[10:8];         // [RQ7]
        end
        if (axi_req_i.wstrb[0]) begin
          n.len[5:0] = axi_req_i.wdata[7:2];                // [RQ7]
        end
      end else if (hit(axi_req_i.awaddr, OFF_CLR)) begin
        n.stat = r.stat & ~axi_req_i.wdata[EV_W-1:0];
      end else if (hit(axi_req_i.awaddr, OFF_IEN)) begin
        n.ien = axi_req_i.wdata[EV_W-1:0];
      end else if (axi_req_i.awaddr >= OFF_BUF) begin
        mem_we = 1'b1;
      end else if (!hit(axi_req_i.awaddr, OFF_STAT)) begin
        n.bresp = RESP_SLVERR;
      end
    end

    // read channel
    if (r.rvalid && axi_req_i.rready) begin
      n.rvalid = 1'b0;
    end
    if (rd_go) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      n.rdata  = 32'h0000_0000;
      if (rd_ctrl) begin
        n.rdata = ctrl_word(r);                             // [RQ7]
      end else if (hit(axi_req_i.araddr, OFF_STAT)) begin
        n.rdata[EV_W-1:0] = r.stat;
      end else if (hit(axi_req_i.araddr, OFF_IEN)) begin
        n.rdata[EV_W-1:0] = r.ien;
      end else if (!hit(axi_req_i.araddr, OFF_CLR) &&
                   axi_req_i.araddr < OFF_BUF) begin
        n.rresp = RESP_SLVERR;
      end
    end

    // transmit engine
    case (r.st)
      ST_IDLE: begin
        if (trig_w && n.eng) begin                          // [RQ4] [RQ5]
          start_go = 1'b1;
          n.st     = ST_FETCH;
          n.run    = 1'b1;                                  // [RQ3]
          n.done   = 1'b0;
          n.waddr  = seg_word(n.seg);                       // [RQ8] [RQ1]
          n.left   = len_words(n.len);                      // [RQ8]
          n.bidx   = 2'h0;
          n.first  = 1'b1;
          n.slot   = 1'b0;
          n.stat[EV_START] = 1'b1;
        end
      end
      ST_FETCH: begin
        mem_re = 1'b1;
        n.st   = ST_SEND;
      end
      ST_SEND: begin
        n.slot = ~r.slot;
        if (r.mode && (!r.slot || r.link.valid)) begin
          n.link.dbus_slot = 1'b1;                          // [RQ6]
        end else begin
          n.link.valid     = 1'b1;
          n.link.dbus_slot = 1'b0;
          n.link.first     = r.first;
          n.link.octet     = mem_rdata[{r.bidx, 3'b000} +: 8];
          n.link.last      = (r.left == 1) && (r.bidx == 2'h3);
          n.first          = 1'b0;
          n.bidx           = r.bidx + 2'h1;
          if (r.bidx == 2'h3) begin
            n.left  = r.left - 1'b1;                        // [RQ8]
            n.waddr = r.waddr + 1'b1;
            n.st    = (r.left == 1) ? ST_END : ST_FETCH;
          end
        end
      end
      ST_END: begin
        n.st    = ST_IDLE;
        n.run   = 1'b0;                                     // [RQ3]
        n.done  = 1'b1;                                     // [RQ2]
        n.stat[EV_DONE] = 1'b1;
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // disable aborts without completing, except from ST_END, where done and the done event are still set
    if (!n.eng && r.st != ST_IDLE) begin                    // [RQ5]
      n.st  = ST_IDLE;
      n.run = 1'b0;
      n.link = '0;
      n.link.dbus_slot = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r      <= '0;
      r.seg  <= SEG_RST;
      r.len  <= LEN_RST;
      r.ien  <= IEN_RST;
      r.st   <= ST_IDLE;
    end else begin
      r <= n;
    end
  end

  sbt_buf_mem #(
    .DEPTH (DEPTH),
    .WIDTH (DATA_W),
    .AW    (AW)
  ) u_mem (
    .core_clk_i (core_clk_i),
    .we_i       (mem_we),
    .waddr_i    (mem_waddr),
    .wdata_i    (axi_req_i.wdata),
    .wstrb_i    (axi_req_i.wstrb),
    .re_i       (mem_re),
    .raddr_i    (mem_raddr),
    .rdata_o    (mem_rdata)
  );

  // checking helpers
  logic [11:0] sent_q;
  logic [11:0] want_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sent_q <= 12'h000;
      want_q <= 12'h000;
    end else if (start_go) begin
      sent_q <= 12'h000;
      want_q <= {n.left, 2'b00};
    end else if (r.link.valid) begin
      sent_q <= sent_q + 12'h001;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_start;
    start_go;
  endsequence

  sequence s_fetch_send;
    r.st == ST_FETCH ##1 r.st == ST_SEND;
  endsequence

  property p_trig_starts;
    s_start |=> (r.run and s_fetch_send);
  endproperty

  chk_trig_starts: assert property (p_trig_starts) // [RQ4]
    else $error("trigger did not start a transfer");

  chk_run_held: assert property ( // [RQ3]
    r.run && r.st != ST_END && n.eng |=> r.run)
    else $error("running flag dropped before completion");

  chk_done_set: assert property ( // [RQ2]
    r.st == ST_END && n.eng |=> r.done && !r.run && r.stat[EV_DONE])
    else $error("complete flag not set at end of transfer");

  chk_first_addr: assert property ( // [RQ1]
    s_start |=> mem_re && mem_raddr == seg_word($past(n.seg)))
    else $error("first read not at start segment");

  chk_byte_count: assert property ( // [RQ8]
    r.link.valid && r.link.last |-> sent_q + 12'h001 == want_q)
    else $error("sent byte count differs from length");

  chk_engine_off: assert property ( // [RQ5]
    !r.eng |-> r.st == ST_IDLE && !r.run && !r.link.valid)
    else $error("engine active while disabled");

  chk_share_alt: assert property ( // [RQ6]
    r.mode && $past(r.mode) && r.link.valid |-> !$past(r.link.valid))
    else $error("shared mode sent data in back to back slots");

  chk_len_read: assert property ( // [RQ7]
    rd_ctrl |=> r.rdata[1:0] == 2'b00 && r.rdata[10:2] == $past(r.len))
    else $error("length field read back wrong");

  chk_irq_done: assert property ( // [RQ2]
    r.st == ST_END && n.eng && n.ien[EV_DONE] |=> irq_o)
    else $error("done interrupt not raised");

  chk_start_stat: assert property ( // [RQ3]
    s_start |=> r.stat[EV_START] && !r.done)
    else $error("start event or done clear missing");

  chk_abort_no_done: assert property ( // [RQ5]
    r.run && r.st != ST_END && !n.eng |=> !r.run && !r.done)
    else $error("aborted transfer reported complete");

  chk_first_flag: assert property ( // [RQ8]
    r.link.valid && r.link.first |-> sent_q == 12'h000)
    else $error("first marker not on first byte");

endmodule
